// [logic/irpdt_pkg.sv]
// Constants and types shared by the infrared pulse-distance transmitter
`default_nettype none
package irpdt_pkg;

	// ----------------------------------------------------------------
	// Clock and carrier timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 20_000_000;
	localparam int unsigned CARRIER_HZ      = 38_000;
	localparam int unsigned CARRIER_CYC     = CLK_HZ / CARRIER_HZ;      // 526 cycles per period
	localparam int unsigned CARRIER_HIGH    = CARRIER_CYC / 2;          // Half high, half low
	localparam int          CAR_W           = 10;

	// ----------------------------------------------------------------
	// Bit and burst durations, in nanoseconds, then in cycles
	// ----------------------------------------------------------------
	localparam int unsigned CLK_NS          = 1_000_000_000 / CLK_HZ;   // 50 ns
	localparam int unsigned BIT_ONE_NS      = 2_250_000;
	localparam int unsigned BIT_ZERO_NS     = 1_125_000;
	localparam int unsigned MARK_A_NS       = 624_000;
	localparam int unsigned MARK_B_NS       = 562_500;
	localparam int unsigned BIT_ONE_CYC     = BIT_ONE_NS / CLK_NS;
	localparam int unsigned BIT_ZERO_CYC    = BIT_ZERO_NS / CLK_NS;
	localparam int unsigned MARK_A_CYC      = (MARK_A_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned MARK_B_CYC      = (MARK_B_NS + CLK_NS - 1) / CLK_NS;

	// Leader defaults (microseconds), overridable at the top
	localparam int unsigned LEAD_A_MARK_US  = 4_500;
	localparam int unsigned LEAD_A_SPACE_US = 4_500;
	localparam int unsigned LEAD_B_MARK_US  = 9_000;
	localparam int unsigned LEAD_B_SPACE_US = 4_500;
	localparam int unsigned US_CYC          = 1_000 / CLK_NS;           // 20 cycles per us

	localparam int          TMR_W           = 19;                       // Fits the 13.5 ms leader
	localparam int          FRAME_BITS      = 32;
	localparam int          BIDX_W          = 6;

	// Reset values
	localparam logic        IR_OUT_RST      = 1'b0;

	// Build-time protocol selection
	typedef enum logic {
		IRPDT_VARIANT_A,
		IRPDT_VARIANT_B
	} irpdt_variant_t;

	typedef enum logic [2:0] {
		IRPDT_IDLE,
		IRPDT_LEAD,
		IRPDT_DATA,
		IRPDT_STOP,
		IRPDT_DONE
	} irpdt_state_t;

endpackage
`default_nettype wire

// [logic/irpdt_carrier_generator.sv]
// Free-running 38 kHz carrier counter with a 50 percent high time
`default_nettype none
module irpdt_carrier_generator (
	input  wire logic clock,
	input  wire logic rst_n,
	output var  logic carrier
);

	logic [irpdt_pkg::CAR_W-1:0] cnt_q;

	// ----------------------------------------------------------------
	// Period counter
	// ----------------------------------------------------------------
	// Runs continuously; the transmitter only gates it, never restarts it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
		end else if (cnt_q == irpdt_pkg::CAR_W'(irpdt_pkg::CARRIER_CYC - 1)) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	// Compare output, high for the first half of each period
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			carrier <= 1'b0;
		end else begin
			carrier <= (cnt_q < irpdt_pkg::CAR_W'(irpdt_pkg::CARRIER_HIGH));
		end
	end

endmodule
`default_nettype wire

// [logic/irpdt_transmitter.sv]
// Infrared pulse-distance transmitter: frame sequencer and bit timer
//
// Overview of operation
// - Variant A: 16-bit address, command, inverted command
// - Variant A marks are 624 us carrier bursts
// - One bit 2.25 ms, zero bit 1.125 ms
// - Carrier high ratio quarter or third, optional
// - Variant B: address, ~address, command, ~command
// - Variant B marks are 562.5 us bursts
// - Variant chosen by parameter, default variant A
// - Frame order: leader, address, then command
// - Output is only the gated continuous carrier
// - Separate carrier counter and bit duration timer
// - Bit timer reloaded per bit from bit value
// - Terminal count ends each bit
// - Compare event ends burst, carrier off after
// - Variant A zero: 0.624 ms on, rest off
// - Carrier is 38 kHz square, half high
`default_nettype none
module irpdt_transmitter #(
	parameter irpdt_pkg::irpdt_variant_t protocol_variant_select = irpdt_pkg::IRPDT_VARIANT_A,
	parameter int unsigned LEAD_MARK_CYC  = 0,  // 0 selects the variant default
	parameter int unsigned LEAD_SPACE_CYC = 0,
	parameter bit          STOP_BURST     = 1'b1
) (
	input  wire logic        clock,
	input  wire logic        rstn,
	input  wire logic        send,
	input  wire logic [15:0] address,
	input  wire logic [7:0]  command,
	output var  logic        busy,
	output var  logic        done,
	output var  logic        ir_out
);

	// ----------------------------------------------------------------
	// Derived timing
	// ----------------------------------------------------------------
	localparam bit VAR_A = (protocol_variant_select == irpdt_pkg::IRPDT_VARIANT_A);
	localparam int unsigned MARK_CYC = VAR_A ? irpdt_pkg::MARK_A_CYC
	                                         : irpdt_pkg::MARK_B_CYC;
	localparam int unsigned LM_DEF = (VAR_A ? irpdt_pkg::LEAD_A_MARK_US
	                                        : irpdt_pkg::LEAD_B_MARK_US) * irpdt_pkg::US_CYC;
	localparam int unsigned LS_DEF = (VAR_A ? irpdt_pkg::LEAD_A_SPACE_US
	                                        : irpdt_pkg::LEAD_B_SPACE_US) * irpdt_pkg::US_CYC;
	localparam int unsigned LM_CYC = (LEAD_MARK_CYC  != 0) ? LEAD_MARK_CYC  : LM_DEF;
	localparam int unsigned LS_CYC = (LEAD_SPACE_CYC != 0) ? LEAD_SPACE_CYC : LS_DEF;
	localparam int W = irpdt_pkg::TMR_W;

	// ----------------------------------------------------------------
	// Reset synchroniser
	// ----------------------------------------------------------------
	logic rst_meta_q;
	logic rst_n;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// Carrier counter (first of the two counters)
	// ----------------------------------------------------------------
	logic carrier;

	irpdt_carrier_generator u_carrier_generator (
		.clock   (clock),
		.rst_n   (rst_n),
		.carrier (carrier)
	);

	// ----------------------------------------------------------------
	// Frame word and sequencer state
	// ----------------------------------------------------------------
	irpdt_pkg::irpdt_state_t state_q;
	logic [irpdt_pkg::FRAME_BITS-1:0] frame_q;
	logic [irpdt_pkg::BIDX_W-1:0]     bidx_q;
	logic [W-1:0]                     tmr_q;
	logic [W-1:0]                     period_q;
	logic [W-1:0]                     compare_q;
	logic                             tc_evt;
	logic                             cmp_evt;
	logic                             gate_q;
	logic                             next_bit;
	logic [irpdt_pkg::FRAME_BITS-1:0] frame_d;

	// Frame layout, sent from bit 0 upward so every field goes LSB first
	always_comb begin
		if (VAR_A) begin
			frame_d = {~command, command, address};
		end else begin
			frame_d = {~command, command, ~address[7:0], address[7:0]};
		end
	end

	// Terminal count and compare events of the bit timer
	assign tc_evt  = (state_q != irpdt_pkg::IRPDT_IDLE)
	               && (state_q != irpdt_pkg::IRPDT_DONE)
	               && (tmr_q == period_q - 1'b1);
	assign cmp_evt = (state_q != irpdt_pkg::IRPDT_IDLE)
	               && (tmr_q == compare_q - 1'b1);
	assign next_bit = frame_q[bidx_q[4:0]];

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Leader, then 32 data bits, then an optional stop burst
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= irpdt_pkg::IRPDT_IDLE;
			frame_q <= '0;
			bidx_q  <= '0;
		end else begin
			unique case (state_q)
				irpdt_pkg::IRPDT_IDLE: begin
					if (send) begin
						frame_q <= frame_d;
						bidx_q  <= '0;
						state_q <= irpdt_pkg::IRPDT_LEAD;
					end
				end
				irpdt_pkg::IRPDT_LEAD: begin
					if (tc_evt) begin
						state_q <= irpdt_pkg::IRPDT_DATA;
					end
				end
				irpdt_pkg::IRPDT_DATA: begin
					if (tc_evt) begin
						if (bidx_q == irpdt_pkg::BIDX_W'(irpdt_pkg::FRAME_BITS - 1)) begin
							state_q <= STOP_BURST ? irpdt_pkg::IRPDT_STOP
							                      : irpdt_pkg::IRPDT_DONE;
						end
						bidx_q <= bidx_q + 1'b1;
					end
				end
				irpdt_pkg::IRPDT_STOP: begin
					if (tc_evt) begin
						state_q <= irpdt_pkg::IRPDT_DONE;
					end
				end
				irpdt_pkg::IRPDT_DONE: begin
					state_q <= irpdt_pkg::IRPDT_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Bit duration timer (second counter)
	// ----------------------------------------------------------------
	// Period and compare are reloaded at each boundary from the next segment
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tmr_q     <= '0;
			period_q  <= '1;
			compare_q <= '1;
		end else if (state_q == irpdt_pkg::IRPDT_IDLE) begin
			tmr_q     <= '0;
			period_q  <= W'(LM_CYC + LS_CYC);
			compare_q <= W'(LM_CYC);
		end else if (tc_evt) begin
			tmr_q <= '0;
			if (state_q == irpdt_pkg::IRPDT_DATA
			    && bidx_q == irpdt_pkg::BIDX_W'(irpdt_pkg::FRAME_BITS - 1)) begin
				period_q  <= W'(MARK_CYC);                               // Stop burst only
				compare_q <= W'(MARK_CYC);
			end else begin
				// The bit now starting is selected by the index after this edge
				period_q  <= (state_q == irpdt_pkg::IRPDT_LEAD ? frame_q[0]
				                                                : frame_q[bidx_q[4:0] + 5'h01])
				           ? W'(irpdt_pkg::BIT_ONE_CYC)
				           : W'(irpdt_pkg::BIT_ZERO_CYC);
				compare_q <= W'(MARK_CYC);
			end
		end else begin
			tmr_q <= tmr_q + 1'b1;
		end
	end

	// Carrier gate: on at each segment start, off at the compare event
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gate_q <= 1'b0;
		end else if (state_q == irpdt_pkg::IRPDT_IDLE) begin
			gate_q <= send;
		end else if (cmp_evt || state_q == irpdt_pkg::IRPDT_DONE) begin
			gate_q <= 1'b0;
		end else if (tc_evt && !(state_q == irpdt_pkg::IRPDT_STOP)
		             && !(state_q == irpdt_pkg::IRPDT_DATA && !STOP_BURST
		                  && bidx_q == irpdt_pkg::BIDX_W'(irpdt_pkg::FRAME_BITS - 1))) begin
			gate_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Outputs, all registered
	// ----------------------------------------------------------------
	// Half-high carrier chosen; quarter or third ratio is advisory only
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ir_out <= irpdt_pkg::IR_OUT_RST;
			busy   <= 1'b0;
			done   <= 1'b0;
		end else begin
			ir_out <= gate_q & carrier;
			busy   <= (state_q != irpdt_pkg::IRPDT_IDLE) || send;
			done   <= (state_q == irpdt_pkg::IRPDT_DONE);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Compare event of the bit timer: burst of the current segment is over
	sequence s_burst_end;
		cmp_evt;
	endsequence

	// Mark part of a data bit or of the stop burst, before the compare point
	sequence s_mark_window;
		(state_q == irpdt_pkg::IRPDT_DATA || state_q == irpdt_pkg::IRPDT_STOP)
		&& tmr_q < W'(MARK_CYC);
	endsequence

	// Space part of a data bit, from the compare point to the terminal count
	sequence s_space_window;
		state_q == irpdt_pkg::IRPDT_DATA && tmr_q >= W'(MARK_CYC);
	endsequence

	a_idle_low: assert property (@(posedge clock) disable iff (!rst_n)
		(state_q == irpdt_pkg::IRPDT_IDLE && !gate_q) |=> !ir_out)
		else $error("ir output high while idle");

	a_gate_off: assert property (@(posedge clock) disable iff (!rst_n)
		s_burst_end |=> !gate_q)
		else $error("carrier gate stays on after burst end");

	a_zero_len: assert property (@(posedge clock) disable iff (!rst_n)
		(tc_evt && state_q == irpdt_pkg::IRPDT_DATA && !next_bit)
		|-> period_q == W'(irpdt_pkg::BIT_ZERO_CYC))
		else $error("zero bit length wrong");

	a_one_len: assert property (@(posedge clock) disable iff (!rst_n)
		(tc_evt && state_q == irpdt_pkg::IRPDT_DATA && next_bit)
		|-> period_q == W'(irpdt_pkg::BIT_ONE_CYC))
		else $error("one bit length wrong");

	a_mark_len: assert property (@(posedge clock) disable iff (!rst_n)
		(state_q == irpdt_pkg::IRPDT_DATA) |-> compare_q == W'(MARK_CYC))
		else $error("mark length wrong");

	a_frame_inv: assert property (@(posedge clock) disable iff (!rst_n)
		(state_q != irpdt_pkg::IRPDT_IDLE) |-> frame_q[31:24] == ~frame_q[23:16])
		else $error("command inverse wrong");

	a_lead_first: assert property (@(posedge clock) disable iff (!rst_n)
		(state_q == irpdt_pkg::IRPDT_IDLE && send) |=> state_q == irpdt_pkg::IRPDT_LEAD)
		else $error("frame does not start with leader");

	a_gated_only: assert property (@(posedge clock) disable iff (!rst_n)
		ir_out |-> $past(carrier) && $past(gate_q))
		else $error("output not a gated carrier");

	a_timer_wrap: assert property (@(posedge clock) disable iff (!rst_n)
		tc_evt |=> tmr_q == '0)
		else $error("bit timer not reloaded");

	// Gate follows the timer position, so a late or early compare shows here
	a_mark_on: assert property (@(posedge clock) disable iff (!rst_n)
		s_mark_window |-> gate_q)
		else $error("carrier gate off inside a mark");

	a_space_off: assert property (@(posedge clock) disable iff (!rst_n)
		s_space_window |-> !gate_q)
		else $error("carrier gate on inside a space");

	a_period_bit: assert property (@(posedge clock) disable iff (!rst_n)
		(state_q == irpdt_pkg::IRPDT_DATA)
		|-> period_q == (next_bit ? W'(irpdt_pkg::BIT_ONE_CYC) : W'(irpdt_pkg::BIT_ZERO_CYC)))
		else $error("bit period not loaded from bit value");

	a_lead_load: assert property (@(posedge clock) disable iff (!rst_n)
		(state_q == irpdt_pkg::IRPDT_LEAD)
		|-> period_q == W'(LM_CYC + LS_CYC) && compare_q == W'(LM_CYC))
		else $error("leader timing not loaded");

	a_addr_inv: assert property (@(posedge clock) disable iff (!rst_n)
		(!VAR_A && state_q != irpdt_pkg::IRPDT_IDLE)
		|-> frame_q[15:8] == ~frame_q[7:0])
		else $error("address inverse wrong");

	a_done_pulse: assert property (@(posedge clock) disable iff (!rst_n)
		done |=> !done)
		else $error("done longer than one cycle");

	a_stop_skip: assert property (@(posedge clock) disable iff (!rst_n)
		!STOP_BURST |-> state_q != irpdt_pkg::IRPDT_STOP)
		else $error("stop burst sent although disabled");

endmodule
`default_nettype wire

// [verification/irpdt_ir_receiver.sv]
// Behavioural television infrared receiver that decodes the LED drive
`default_nettype none
module irpdt_ir_receiver (
	input  wire logic        clock,
	input  wire logic        ir,
	output var  logic [31:0] word,
	output var  int          n_marks,
	output var  int          lead_per,
	output var  int          mark_min,
	output var  int          mark_max,
	output var  int          car_per
);
	timeunit 1ns;
	timeprecision 1ns;
	int   t;
	int   start_t;
	int   high_t;
	int   rise_t;
	logic in_mark;
	logic ir_q;
	initial begin
		t = 0;
		in_mark = 1'b0;
		ir_q = 1'b0;
		n_marks = 0;
		word = 32'h0;
		mark_min = 1 << 30;
		mark_max = 0;
		car_per = 0;
		lead_per = 0;
	end
	// Mark opens on first carrier high, closes after 400 dark cycles
	// Sampled on the falling edge, away from the edge that launches the output
	always @(negedge clock) begin
		t = t + 1;
		if (ir === 1'b1) begin
			if (ir_q !== 1'b1 && in_mark) car_per = t - rise_t;
			if (ir_q !== 1'b1) rise_t = t;
			if (!in_mark) begin
				// Bit value is read from mark-start spacing
				if (n_marks == 1) lead_per = t - start_t;
				else if (n_marks >= 2 && n_marks <= 33) word[n_marks - 2] = (t - start_t) > 33750;
				start_t = t;
				in_mark = 1'b1;
				n_marks = n_marks + 1;
			end
			high_t = t;
		end else if (in_mark && t - high_t > 400) begin
			in_mark = 1'b0;
			// Only data marks are measured, leader and stop excluded
			if (n_marks >= 2 && n_marks <= 33) begin
				if (high_t - start_t + 1 < mark_min) mark_min = high_t - start_t + 1;
				if (high_t - start_t + 1 > mark_max) mark_max = high_t - start_t + 1;
			end
		end
		ir_q = ir;
	end
endmodule
`default_nettype wire

// [verification/irpdt_transmitter_tb.sv]
// Self-checking bench running both protocol variants side by side
`default_nettype none
module irpdt_transmitter_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// Shortened leader keeps the run down; bit times are fixed
	localparam int unsigned LM = 2000;
	localparam int unsigned LS = 2000;
	// Default leader of the third build, mark plus space, in cycles
	localparam int LD = int'((irpdt_pkg::LEAD_A_MARK_US + irpdt_pkg::LEAD_A_SPACE_US)
	                         * irpdt_pkg::US_CYC);
	logic        clock;
	logic        rstn;
	logic        send;
	logic [15:0] address;
	logic [7:0]  command;
	logic        busy_a, done_a, ir_a, busy_b, done_b, ir_b, busy_c, done_c, ir_c;
	logic [31:0] word_a, word_b, word_c;
	int          nm_a, nm_b, lp_a, lp_b, mn_a, mn_b, mx_a, mx_b, cp_a, cp_b;
	int          nm_c, lp_c, mn_c, mx_c, cp_c;
	int          num_errors;
	int          n_tests;

	// ----------------------------------------------------------------
	// Clock, design instances and receivers
	// ----------------------------------------------------------------
	initial clock = 1'b0;
	always #25 clock = ~clock;

	irpdt_transmitter #(.LEAD_MARK_CYC(LM), .LEAD_SPACE_CYC(LS)) dut (
		.clock(clock), .rstn(rstn), .send(send), .address(address),
		.command(command), .busy(busy_a), .done(done_a), .ir_out(ir_a));
	irpdt_transmitter #(.protocol_variant_select(irpdt_pkg::IRPDT_VARIANT_B),
		.LEAD_MARK_CYC(LM), .LEAD_SPACE_CYC(LS)) dut_b (
		.clock(clock), .rstn(rstn), .send(send), .address(address),
		.command(command), .busy(busy_b), .done(done_b), .ir_out(ir_b));
	irpdt_ir_receiver rx_a (.clock(clock), .ir(ir_a), .word(word_a), .n_marks(nm_a),
		.lead_per(lp_a), .mark_min(mn_a), .mark_max(mx_a), .car_per(cp_a));
	irpdt_ir_receiver rx_b (.clock(clock), .ir(ir_b), .word(word_b), .n_marks(nm_b),
		.lead_per(lp_b), .mark_min(mn_b), .mark_max(mx_b), .car_per(cp_b));
	// Third build: default leader lengths and no stop burst
	irpdt_transmitter #(.STOP_BURST(1'b0)) dut_c (
		.clock(clock), .rstn(rstn), .send(send), .address(address),
		.command(command), .busy(busy_c), .done(done_c), .ir_out(ir_c));
	irpdt_ir_receiver rx_c (.clock(clock), .ir(ir_c), .word(word_c), .n_marks(nm_c),
		.lead_per(lp_c), .mark_min(mn_c), .mark_max(mx_c), .car_per(cp_c));

	// ----------------------------------------------------------------
	// Shared checking and closing
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("Counts: %0d checks, %0d mismatches", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// Output stays dark and idle before any frame
	task automatic t_idle();
		repeat (50) begin
			@(negedge clock);
			check({26'h0, busy_a, busy_b, busy_c, ir_a, ir_b, ir_c}, 32'h0);
		end
		$display("t_idle done");
	endtask

	// Start a frame, then try a second send that must be ignored
	task automatic t_start();
		@(negedge clock);
		send = 1'b1;
		address = 16'h0081;
		command = 8'h3c;
		@(negedge clock);
		send = 1'b0;
		check({29'h0, busy_a, busy_b, busy_c}, 32'h7);
		@(negedge clock);
		send = 1'b1;
		address = 16'hffff;
		command = 8'hff;
		@(negedge clock);
		send = 1'b0;
		$display("t_start done");
	endtask

	// Wait all three frames out, then judge the decoded wire traffic
	task automatic t_frame();
		int i;
		int da;
		int db;
		int dc;
		da = 0;
		db = 0;
		dc = 0;
		for (i = 0; i < 1_300_000 && (da == 0 || db == 0 || dc == 0); i++) begin
			@(negedge clock);
			if (done_a === 1'b1) da++;
			if (done_b === 1'b1) db++;
			if (done_c === 1'b1) dc++;
		end
		// A hang counts as a mismatch and goes straight to the verdict
		if (da == 0 || db == 0 || dc == 0) begin
			num_errors++;
			$display("BAD %0t frame did not finish", $time);
			return;
		end
		// Builds A and B end earlier, so their whole done pulse was counted
		check(da, 1);
		check(db, 1);
		repeat (600) @(negedge clock);
		check({23'h0, done_a, done_b, done_c, busy_a, busy_b, busy_c, ir_a, ir_b, ir_c},
		      32'h0);
		check({ ~8'h3c, 8'h3c, 16'h0081 }, word_a);
		check({ ~8'h3c, 8'h3c, ~8'h81, 8'h81 }, word_b);
		check(nm_a, 34);
		check(nm_b, 34);
		check({31'h0, lp_a > 3474 && lp_a < 4526}, 32'h1);
		check({31'h0, lp_b > 3474 && lp_b < 4526}, 32'h1);
		check({31'h0, mn_a > int'(irpdt_pkg::MARK_A_CYC) - 600}, 32'h1);
		check({31'h0, mx_a <= int'(irpdt_pkg::MARK_A_CYC) + 2}, 32'h1);
		check({31'h0, mn_b > int'(irpdt_pkg::MARK_B_CYC) - 600}, 32'h1);
		check({31'h0, mx_b <= int'(irpdt_pkg::MARK_B_CYC) + 2}, 32'h1);
		check(cp_a, 526);
		check(cp_b, 526);
		// Without a stop burst the last bit has no closing mark to time it by
		check(word_c, {~8'h3c, 8'h3c, 16'h0081} & 32'h7fff_ffff);
		check(nm_c, 33);
		check({31'h0, lp_c > LD - 526 && lp_c < LD + 526}, 32'h1);
		check({31'h0, mn_c > int'(irpdt_pkg::MARK_A_CYC) - 600}, 32'h1);
		check({31'h0, mx_c <= int'(irpdt_pkg::MARK_A_CYC) + 2}, 32'h1);
		check(cp_c, 526);
		$display("t_frame done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		num_errors = 0;
		n_tests = 0;
		rstn = 1'b0;
		send = 1'b0;
		address = 16'h0;
		command = 8'h0;
		repeat (20) @(negedge clock);
		rstn = 1'b1;
		t_idle();
		t_start();
		t_frame();
		end_sim();
	end
endmodule
`default_nettype wire
